// ---- sctp_map.svh ----
/*
 * Register offsets, control field positions, codes and timing constants of
 * the four-instance single-channel timer/PWM block.
 * Assumes it is included by its bare name from each design file.
 */
`ifndef SCTP_MAP_SVH
`define SCTP_MAP_SVH

// word offsets inside one instance window
`define SCTP_OFS_CTRL   2'h0
`define SCTP_OFS_MOD    2'h1
`define SCTP_OFS_VAL    2'h2
`define SCTP_OFS_CNT    2'h3

// shared registers
`define SCTP_ADR_STATUS 5'h10
`define SCTP_ADR_MASK   5'h11

// control register layout
`define SCTP_CTRL_W     10
`define SCTP_CTRL_RST   10'h000
`define SCTP_CTRL_EN    0
`define SCTP_CTRL_SRC   1
`define SCTP_CTRL_PS    4:2
`define SCTP_CTRL_MODE  6:5
`define SCTP_CTRL_SEL   8:7
`define SCTP_CTRL_POL   9

// capture edge codes
`define SCTP_CAP_RISE   2'h1
`define SCTP_CAP_FALL   2'h2
`define SCTP_CAP_BOTH   2'h3

// compare action codes
`define SCTP_ACT_TOGGLE 2'h1
`define SCTP_ACT_CLEAR  2'h2
`define SCTP_ACT_SET    2'h3

// reference oscillator divider and prescaler width
`define SCTP_REFDIV     1024
`define SCTP_REFDIV_W   10
`define SCTP_PS_W       7

`endif

// ---- sctp_pkg.sv ----
/*
 * Types shared by the timer/PWM block.
 * Assumes nothing of its surroundings.
 */
package sctp_pkg;

   // gray order along capture, compare, edge pwm, centre pwm
   typedef enum logic [1:0] {
      SCTP_CAPTURE = 2'h0,
      SCTP_COMPARE = 2'h1,
      SCTP_EPWM    = 2'h3,
      SCTP_CENTER  = 2'h2
   } sctp_mode_e;

endpackage

// ---- sctp_tick.sv ----
/*
 * Count-enable generator of one timer instance: source choice between every
 * clock and the reference oscillator divided down, then a power-of-two
 * prescaler.
 * Assumes ref_rise_in is a one-cycle pulse already synchronised to clk_in.
 */
`include "sctp_map.svh"

module sctp_tick (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       en_in,
   input  wire logic       src_in,
   input  wire logic [2:0] ps_in,
   input  wire logic       ref_rise_in,
   output logic            tick_out
);

   logic [`SCTP_REFDIV_W-1:0] ref_cnt;
   logic [`SCTP_PS_W-1:0]     ps_cnt;
   logic                      ref_tc;
   logic                      src_tick;
   logic [`SCTP_PS_W-1:0]     tap;

   function automatic logic [`SCTP_PS_W-1:0] ps_mask(input logic [2:0] ps);
      ps_mask = `SCTP_PS_W'((8'h1 << ps) - 8'h1);
   endfunction

   assign ref_tc   = ref_rise_in && (ref_cnt == `SCTP_REFDIV_W'(`SCTP_REFDIV - 1));
   assign src_tick = src_in ? ref_tc : 1'b1; // [R4]
   assign tap      = ps_mask(ps_in);
   assign tick_out = en_in && src_tick && ((ps_cnt & tap) == tap); // [R5]

   always_ff @(posedge clk_in) begin
      if (rst_in || !en_in) begin
         ref_cnt <= '0;
      end else if (ref_rise_in) begin
         ref_cnt <= ref_cnt + 1'b1; // [R4]
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || !en_in) begin
         ps_cnt <= '0;
      end else if (src_tick) begin
         ps_cnt <= ps_cnt + 1'b1; // [R5]
      end
   end

endmodule

// ---- sctp_core.sv ----
/*
 * Counter and channel of one timer instance: free-running or up/down count,
 * modulus limit, capture, compare and buffered edge/centre pwm.
 * Assumes tick_in is a count enable and pin_in is synchronised to clk_in.
 */
`include "sctp_map.svh"

module sctp_core #(
   parameter int CW = 16
) (
   input  wire logic          clk_in,
   input  wire logic          rst_in,
   input  wire logic          en_in,
   input  wire logic          tick_in,
   input  wire logic [1:0]    mode_in,
   input  wire logic [1:0]    sel_in,
   input  wire logic          pol_in,
   input  wire logic [CW-1:0] mod_in,
   input  wire logic [CW-1:0] val_in,
   input  wire logic          cnt_clr_in,
   input  wire logic          pin_in,
   output logic [CW-1:0]      cnt_out,
   output logic [CW-1:0]      cap_out,
   output logic               pin_out,
   output logic               ch_evt_out,
   output logic               tc_evt_out
);

   logic [CW-1:0] mod_act;
   logic [CW-1:0] val_act;
   logic [CW-1:0] lim;
   logic          down;
   logic          pin_d;
   logic          pwm;
   logic          center;
   logic          capt;
   logic          at_lim;
   logic          at_zero;
   logic          bound;
   logic          match;
   logic          edge_hit;

   assign center  = mode_in == sctp_pkg::SCTP_CENTER;
   assign capt    = mode_in == sctp_pkg::SCTP_CAPTURE;
   assign pwm     = center || (mode_in == sctp_pkg::SCTP_EPWM);
   // a zero modulus lets the counter run over the full range
   assign lim     = (mod_act == '0) ? '1 : mod_act;
   assign at_lim  = cnt_out == lim;
   assign at_zero = cnt_out == '0;
   assign bound   = center ? (at_zero && down) : at_lim;
   assign match   = cnt_out == val_act;

   always_comb begin
      case (sel_in)
         `SCTP_CAP_RISE: edge_hit = pin_in && !pin_d;
         `SCTP_CAP_FALL: edge_hit = !pin_in && pin_d;
         `SCTP_CAP_BOTH: edge_hit = pin_in ^ pin_d;
         default:        edge_hit = 1'b0;
      endcase
   end

   // while enabled, pwm values only move over at a period boundary
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mod_act <= '0;
         val_act <= '0;
      end else if (!pwm || !en_in || (tick_in && bound)) begin // [R14]
         mod_act <= mod_in; // [R7]
         val_act <= val_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || cnt_clr_in) begin
         cnt_out <= '0;
         down    <= 1'b0;
      end else if (tick_in) begin // [R15]
         if (!center) begin
            down    <= 1'b0;
            cnt_out <= at_lim ? '0 : cnt_out + 1'b1; // [R2] [R6] [R7]
         end else if (!down) begin
            down    <= at_lim; // [R10]
            cnt_out <= at_lim ? cnt_out - 1'b1 : cnt_out + 1'b1;
         end else begin
            down    <= !at_zero; // [R6]
            cnt_out <= at_zero ? cnt_out + 1'b1 : cnt_out - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tc_evt_out <= 1'b0;
         ch_evt_out <= 1'b0;
      end else begin
         tc_evt_out <= tick_in && at_lim && !(center && down); // [R8]
         ch_evt_out <= en_in && (capt ? edge_hit : (tick_in && match)); // [R8] [R15]
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pin_d   <= 1'b0;
         cap_out <= '0;
      end else begin
         pin_d <= pin_in;
         if (en_in && capt && edge_hit) begin
            cap_out <= cnt_out; // [R11]
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pin_out <= 1'b0;
      end else if (en_in && pwm) begin
         pin_out <= (cnt_out < val_act) ^ pol_in; // [R9] [R10] [R13]
      end else if (en_in && !capt && tick_in && match) begin
         case (sel_in)
            `SCTP_ACT_TOGGLE: pin_out <= !pin_out; // [R12]
            `SCTP_ACT_CLEAR:  pin_out <= 1'b0;
            `SCTP_ACT_SET:    pin_out <= 1'b1;
            default:          pin_out <= pin_out;
         endcase
      end
   end

endmodule

// ---- sctp_timer_pwm.sv ----
/*
 * Top of the timer/PWM block: register port, four independent single-channel
 * timer instances, pin synchronisers and the shared interrupt status.
 * Assumes a master on clk_in that pulses wr_in or rd_in for one cycle and
 * takes read data in the cycle after a read strobe.
 */
// Our own choices: the address map and the strobed register port.
// Notes on behaviour
// R1: four independent single-channel instances; only the reference synchroniser, register port and interrupt status/mask are shared
// R2: sixteen-bit counter is the time base
// R3: one pin: capture input or compare/pwm output
// R4: clock source: every clock or reference/1024
// R5: prescaler divides by 1 to 128
// R6: free-running up, up/down in centre pwm
// R7: modulus sets terminal count
// R8: channel interrupt and terminal-count interrupt
// R9: channel modes: capture, compare, edge pwm
// R10: centre-aligned buffered pwm uses up/down count
// R11: capture on rising, falling or either edge
// R12: compare match sets, clears or toggles pin
// R13: pwm output polarity selectable
// R14: pwm updates apply at period boundary
// R15: disabled: counter holds, no events, pin released
`include "sctp_map.svh"

module sctp_timer_pwm #(
   parameter int N  = 4,
   parameter int CW = 16,
   parameter int AW = 5,
   parameter int DW = 16
) (
   input  wire logic          clk_in,
   input  wire logic          rst_in,
   input  wire logic [AW-1:0] addr_in,
   input  wire logic [DW-1:0] wdata_in,
   input  wire logic          wr_in,
   input  wire logic          rd_in,
   output logic [DW-1:0]      rdata_out,
   input  wire logic          ref_osc_in,
   input  wire logic [N-1:0]  pin_in,
   output logic [N-1:0]       pin_out,
   output logic [N-1:0]       pin_oe_n_out,
   output logic               irq_out
);

   logic [`SCTP_CTRL_W-1:0] ctrl     [N];
   logic [CW-1:0]           mod_buf  [N];
   logic [CW-1:0]           val_buf  [N];
   logic [CW-1:0]           cnt      [N];
   logic [CW-1:0]           cap      [N];
   logic [N-1:0]            tick;
   logic [N-1:0]            cnt_clr;
   logic [N-1:0]            ch_evt;
   logic [N-1:0]            tc_evt;
   logic [N-1:0]            pin_s1;
   logic [N-1:0]            pin_s2;
   logic                    ref_s1;
   logic                    ref_s2;
   logic                    ref_s3;
   logic                    ref_rise;
   logic [2*N-1:0]          status;
   logic [2*N-1:0]          mask;
   logic [2*N-1:0]          w1c;
   logic [DW-1:0]           next_rdata;

   function automatic logic hit(input logic [AW-1:0] a, input int i,
                                input logic [1:0] ofs);
      hit = (a[4] == 1'b0) && (a[3:2] == 2'(i)) && (a[1:0] == ofs);
   endfunction

   // pin and reference inputs cross in through two flops
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ref_s1 <= 1'b0;
         ref_s2 <= 1'b0;
         ref_s3 <= 1'b0;
      end else begin
         ref_s1 <= ref_osc_in;
         ref_s2 <= ref_s1;
         ref_s3 <= ref_s2;
      end
   end

   assign ref_rise = ref_s2 && !ref_s3;

   // one set of registers, divider and channel per instance
   for (genvar i = 0; i < N; i++) begin : g_inst // [R1]

      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            ctrl[i] <= `SCTP_CTRL_RST;
         end else if (wr_in && hit(addr_in, i, `SCTP_OFS_CTRL)) begin
            ctrl[i] <= wdata_in[`SCTP_CTRL_W-1:0];
         end
      end

      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            mod_buf[i] <= '0;
         end else if (wr_in && hit(addr_in, i, `SCTP_OFS_MOD)) begin
            mod_buf[i] <= wdata_in[CW-1:0]; // [R7]
         end
      end

      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            val_buf[i] <= '0;
         end else if (wr_in && hit(addr_in, i, `SCTP_OFS_VAL)) begin
            val_buf[i] <= wdata_in[CW-1:0];
         end
      end

      // a write to the counter word restarts the count
      assign cnt_clr[i] = wr_in && hit(addr_in, i, `SCTP_OFS_CNT);

      sctp_tick u_tick (
         .clk_in      (clk_in),
         .rst_in      (rst_in),
         .en_in       (ctrl[i][`SCTP_CTRL_EN]),
         .src_in      (ctrl[i][`SCTP_CTRL_SRC]),
         .ps_in       (ctrl[i][`SCTP_CTRL_PS]),
         .ref_rise_in (ref_rise),
         .tick_out    (tick[i])
      );

      sctp_core #(
         .CW (CW)
      ) u_core (
         .clk_in     (clk_in),
         .rst_in     (rst_in),
         .en_in      (ctrl[i][`SCTP_CTRL_EN]),
         .tick_in    (tick[i]),
         .mode_in    (ctrl[i][`SCTP_CTRL_MODE]),
         .sel_in     (ctrl[i][`SCTP_CTRL_SEL]),
         .pol_in     (ctrl[i][`SCTP_CTRL_POL]),
         .mod_in     (mod_buf[i]),
         .val_in     (val_buf[i]),
         .cnt_clr_in (cnt_clr[i]),
         .pin_in     (pin_s2[i]),
         .cnt_out    (cnt[i]),
         .cap_out    (cap[i]),
         .pin_out    (pin_out[i]),
         .ch_evt_out (ch_evt[i]),
         .tc_evt_out (tc_evt[i])
      );

      // drive only when enabled and not capturing
      assign pin_oe_n_out[i] = !ctrl[i][`SCTP_CTRL_EN] ||
                               (ctrl[i][`SCTP_CTRL_MODE] == sctp_pkg::SCTP_CAPTURE); // [R3] [R15]
   end

   // sticky status, write one to clear, a new event wins
   assign w1c = (wr_in && (addr_in == `SCTP_ADR_STATUS)) ? wdata_in[2*N-1:0] : '0;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         status <= '0;
      end else begin
         status <= (status & ~w1c) | {tc_evt, ch_evt}; // [R8]
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mask <= '0;
      end else if (wr_in && (addr_in == `SCTP_ADR_MASK)) begin
         mask <= wdata_in[2*N-1:0];
      end
   end

   assign irq_out = |(status & mask); // [R8]

   always_comb begin
      next_rdata = '0;
      if (addr_in == `SCTP_ADR_STATUS) begin
         next_rdata = DW'(status);
      end else if (addr_in == `SCTP_ADR_MASK) begin
         next_rdata = DW'(mask);
      end
      for (int i = 0; i < N; i++) begin
         if (hit(addr_in, i, `SCTP_OFS_CTRL)) begin
            next_rdata = DW'(ctrl[i]);
         end
         if (hit(addr_in, i, `SCTP_OFS_MOD)) begin
            next_rdata = DW'(mod_buf[i]);
         end
         if (hit(addr_in, i, `SCTP_OFS_VAL)) begin
            next_rdata = (ctrl[i][`SCTP_CTRL_MODE] == sctp_pkg::SCTP_CAPTURE) ?
                         DW'(cap[i]) : DW'(val_buf[i]); // [R11]
         end
         if (hit(addr_in, i, `SCTP_OFS_CNT)) begin
            next_rdata = DW'(cnt[i]);
         end
      end
   end

   // read data stands for exactly one cycle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= rd_in ? next_rdata : '0;
      end
   end

   // checks on single instances and the shared status
   logic       en0;
   logic [1:0] mode0;
   logic [1:0] mode1;
   logic [1:0] mode3;

   assign en0   = ctrl[0][`SCTP_CTRL_EN];
   assign mode0 = ctrl[0][`SCTP_CTRL_MODE];
   assign mode1 = ctrl[1][`SCTP_CTRL_MODE];
   assign mode3 = ctrl[3][`SCTP_CTRL_MODE];

   default clocking cb @(posedge clk_in);
   endclocking

   default disable iff (rst_in);

   sequence s_clear0;
      wr_in && (addr_in == `SCTP_ADR_STATUS) && wdata_in[0];
   endsequence

   sequence s_rd_status;
      rd_in && (addr_in == `SCTP_ADR_STATUS);
   endsequence

   sequence s_off2;
      (!en0 && !cnt_clr[0]) ##1 !en0;
   endsequence

   a_chan_evt_sticky: assert property ( // [R8]
      ch_evt[0] |=> status[0])
      else $error("channel event not latched in status");

   a_tc_evt_sticky: assert property ( // [R8]
      tc_evt[1] |=> status[N+1])
      else $error("terminal count event not latched in status");

   a_set_beats_clear: assert property ( // [R8]
      (s_clear0 and ch_evt[0]) |=> status[0])
      else $error("event lost while its flag was cleared");

   a_w1c_clears: assert property ( // [R8]
      (s_clear0 and !ch_evt[0]) |=> !status[0])
      else $error("write one did not clear status");

   a_irq_masked: assert property ( // [R8]
      (status[N+1] && mask[N+1]) |-> irq_out ##1 (irq_out || !status[N+1] || !mask[N+1]))
      else $error("unmasked status did not raise interrupt");

   a_irq_quiet: assert property ( // [R8]
      ((status & mask) == '0) |-> !irq_out)
      else $error("interrupt without unmasked status");

   a_off_no_evt: assert property ( // [R15]
      (!en0 && !$past(en0)) |-> (!ch_evt[0] && !tc_evt[0]) ##1 !ch_evt[0])
      else $error("event raised while instance disabled");

   a_off_hold: assert property ( // [R15]
      s_off2 |-> $stable(cnt[0]))
      else $error("counter moved while disabled");

   a_off_release: assert property ( // [R15]
      !en0 |-> pin_oe_n_out[0])
      else $error("pin driven while disabled");

   a_cap_input: assert property ( // [R3]
      (en0 && (mode0 == sctp_pkg::SCTP_CAPTURE)) |-> pin_oe_n_out[0])
      else $error("pin driven in capture mode");

   a_out_drive: assert property ( // [R3]
      (en0 && (mode0 != sctp_pkg::SCTP_CAPTURE)) |-> !pin_oe_n_out[0])
      else $error("pin not driven in output mode");

   a_wrap_zero: assert property ( // [R7]
      (tc_evt[1] && (mode1 != sctp_pkg::SCTP_CENTER) && $stable(mode1)) |-> (cnt[1] == '0))
      else $error("counter did not wrap to zero at terminal count");

   a_center_turn: assert property ( // [R6]
      (tc_evt[3] && (mode3 == sctp_pkg::SCTP_CENTER) && $stable(mode3) && !$past(cnt_clr[3]))
      |-> (cnt[3] == ($past(cnt[3]) - 16'h1)))
      else $error("centre pwm did not turn down at the limit");

   a_read_status: assert property ( // [R8]
      s_rd_status |=> (rdata_out == DW'($past(status))))
      else $error("status read returned wrong data");

   a_read_once: assert property (
      !rd_in |=> (rdata_out == '0))
      else $error("read data held past its cycle");

endmodule

// ---- sctp_timer_pwm_bench.sv ----
/*
 * Self-checking bench of the four-instance timer/PWM block: register port
 * traffic, prescaler, reference source, terminal count, compare, pwm, capture.
 * Assumes the design files and sctp_map.svh are compiled before it.
 */
`include "sctp_map.svh"

module sctp_timer_pwm_bench;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [15:0] exp;
      logic [15:0] msk;
   } sctp_note_s;

   localparam logic [1:0] m_cap  = 2'(sctp_pkg::SCTP_CAPTURE);
   localparam logic [1:0] m_cmp  = 2'(sctp_pkg::SCTP_COMPARE);
   localparam logic [1:0] m_epwm = 2'(sctp_pkg::SCTP_EPWM);
   localparam logic [1:0] m_cent = 2'(sctp_pkg::SCTP_CENTER);

   logic        clk_in;
   logic        rst_in;
   logic [4:0]  addr_in;
   logic [15:0] wdata_in;
   logic        wr_in;
   logic        rd_in;
   logic [15:0] rdata_out;
   logic        ref_osc_in = 1'b0;
   logic [3:0]  pin_in;
   logic [3:0]  pin_out;
   logic [3:0]  pin_oe_n_out;
   logic        irq_out;
   logic        rd_seen;
   logic [15:0] last_rd;
   logic [15:0] a;
   logic        p;
   sctp_note_s  note;
   sctp_note_s  notes[$];
   int          n_errors;
   int          checks_done;
   int          seed;
   int          h;
   int          r;
   int          run;
   int          v;

   sctp_timer_pwm u_sctp_timer_pwm (
      .clk_in       (clk_in),
      .rst_in       (rst_in),
      .addr_in      (addr_in),
      .wdata_in     (wdata_in),
      .wr_in        (wr_in),
      .rd_in        (rd_in),
      .rdata_out    (rdata_out),
      .ref_osc_in   (ref_osc_in),
      .pin_in       (pin_in),
      .pin_out      (pin_out),
      .pin_oe_n_out (pin_oe_n_out),
      .irq_out      (irq_out)
   );

   initial clk_in = 1'b0;
   always #10 clk_in = ~clk_in;

   // reference oscillator at half the clock rate
   always @(posedge clk_in) ref_osc_in <= ~ref_osc_in;

   always @(posedge clk_in) rd_seen <= rd_in;

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask

   // read data stand only in the cycle after the strobe
   always @(negedge clk_in) begin
      if (rd_seen === 1'b1) begin
         note = notes.pop_front();
         last_rd = rdata_out;
         check({16'h0000, rdata_out & note.msk}, {16'h0000, note.exp & note.msk});
      end
   end

   task summarize;
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task wr(input logic [4:0] ad_w, input logic [15:0] d);
      addr_in <= ad_w;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task rd(input logic [4:0] ad_r, input logic [15:0] e, input logic [15:0] m);
      notes.push_back('{exp: e, msk: m});
      addr_in <= ad_r;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(posedge clk_in);
   endtask

   // counter advance over exactly n cycles, seen through two reads
   task delta(input int i, input int n, input logic [15:0] e);
      rd({i[2:0], 2'h3}, 16'h0000, 16'h0000);
      a = last_rd;
      repeat (n - 2) @(posedge clk_in);
      rd({i[2:0], 2'h3}, 16'h0000, 16'h0000);
      check({16'h0000, 16'(last_rd - a)}, {16'h0000, e});
   endtask

   task count_high(input int n);
      h = 0;
      r = 0;
      run = 0;
      repeat (n) begin
         @(negedge clk_in);
         h += int'(pin_out[3]);
         run = (pin_out[3] === 1'b1) ? run + 1 : 0;
         if (run > r) r = run;
      end
      @(posedge clk_in);
   endtask

   function automatic logic [15:0] cw(input logic [1:0] md, input logic [1:0] sl,
                                      input logic pl, input logic [2:0] ps, input logic src);
      return {6'h00, pl, sl, md, ps, src, 1'b1};
   endfunction

   initial begin
      repeat (40000) @(posedge clk_in);
      n_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      summarize();
   end

   initial begin
      seed = 72596;
      n_errors = 0;
      checks_done = 0;
      rst_in = 1'b1;
      addr_in = 5'h00;
      wdata_in = 16'h0000;
      wr_in = 1'b0;
      rd_in = 1'b0;
      pin_in = 4'h0;
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      pin_in[3:1] <= 3'($random(seed));
      @(negedge clk_in);
      check({28'h0000000, pin_oe_n_out}, 32'h0000000F);
      check({31'h00000000, irq_out}, 32'h00000000);
      @(posedge clk_in);
      for (int i = 0; i < 4; i++) rd(5'(i * 4), 16'h0000, 16'hFFFF);
      rd(5'h12, 16'h0000, 16'hFFFF);
      rd(`SCTP_ADR_STATUS, 16'h0000, 16'hFFFF);
      for (int k = 0; k < 8; k++) begin
         wr(5'h00, cw(m_cmp, 2'h0, 1'b0, 3'(k), 1'b0));
         delta(0, 512, 16'(512 >> k));
      end
      wr(5'h00, 16'h0000);
      delta(0, 64, 16'h0000);
      wr(5'h00, cw(m_cmp, 2'h0, 1'b0, 3'h0, 1'b1));
      delta(0, 4096, 16'h0002);
      wr(5'h00, 16'h0000);
      wr(5'h05, 16'h0009);
      wr(5'h04, cw(m_cmp, 2'h0, 1'b0, 3'h0, 1'b0));
      repeat (12) begin
         rd(5'h07, 16'h0000, 16'h0000);
         check({31'h00000000, last_rd <= 16'h0009}, 32'h00000001);
      end
      rd(`SCTP_ADR_STATUS, 16'h0020, 16'h0020);
      check({31'h00000000, irq_out}, 32'h00000000);
      wr(`SCTP_ADR_MASK, 16'h0020);
      @(negedge clk_in);
      check({31'h00000000, irq_out}, 32'h00000001);
      @(posedge clk_in);
      wr(5'h04, 16'h0000);
      repeat (4) @(posedge clk_in);
      wr(`SCTP_ADR_STATUS, 16'h0020);
      @(negedge clk_in);
      check({31'h00000000, irq_out}, 32'h00000000);
      check({31'h00000000, pin_oe_n_out[1]}, 32'h00000001);
      @(posedge clk_in);
      wr(5'h09, 16'h000F);
      wr(5'h0A, 16'h0005);
      for (int s = 3; s > 1; s--) begin
         wr(5'h08, cw(m_cmp, 2'(s), 1'b0, 3'h0, 1'b0));
         repeat (40) @(posedge clk_in);
         @(negedge clk_in);
         check({31'h00000000, pin_out[2]}, 32'(s & 1));
         check({31'h00000000, pin_oe_n_out[2]}, 32'h00000000);
         @(posedge clk_in);
      end
      wr(5'h08, cw(m_cmp, `SCTP_ACT_TOGGLE, 1'b0, 3'h0, 1'b0));
      repeat (20) @(posedge clk_in);
      @(negedge clk_in);
      p = pin_out[2];
      repeat (16) @(negedge clk_in);
      check({31'h00000000, pin_out[2]}, {31'h00000000, ~p});
      @(posedge clk_in);
      rd(`SCTP_ADR_STATUS, 16'h0004, 16'h0004);
      wr(5'h08, 16'h0000);
      wr(5'h0D, 16'h0063);
      for (int j = 0; j < 4; j++) begin
         v = ($random(seed) & 32'h7FFFFFFF) % 100;
         wr(5'h0E, 16'(v));
         wr(5'h0C, cw(m_epwm, 2'h0, 1'(j & 1), 3'h0, 1'b0));
         repeat (300) @(posedge clk_in);
         count_high(100);
         check(32'(h), 32'((j & 1) != 0 ? 100 - v : v));
      end
      wr(5'h0E, 16'h0019);
      wr(5'h0C, cw(m_cent, 2'h0, 1'b0, 3'h0, 1'b0));
      repeat (400) @(posedge clk_in);
      count_high(400);
      check({31'h00000000, r >= 48 && r <= 51}, 32'h00000001);
      wr(5'h0C, 16'h0000);
      for (int s = 1; s < 4; s++) begin
         wr(5'h00, cw(m_cap, 2'(s), 1'b0, 3'h0, 1'b0));
         repeat (8) @(posedge clk_in);
         check({31'h00000000, pin_oe_n_out[0]}, 32'h00000001);
         wr(`SCTP_ADR_STATUS, 16'h0001);
         wr(5'h03, 16'h0000);
         pin_in[0] <= 1'b1;
         repeat (8) @(posedge clk_in);
         rd(`SCTP_ADR_STATUS, 16'(s & 1), 16'h0001);
         rd(5'h02, 16'h0003, 16'hFFFF);
         wr(`SCTP_ADR_STATUS, 16'h0001);
         wr(5'h03, 16'h0000);
         pin_in[0] <= 1'b0;
         repeat (8) @(posedge clk_in);
         rd(`SCTP_ADR_STATUS, 16'(s >> 1), 16'h0001);
         rd(5'h02, 16'h0003, 16'hFFFF);
      end
      repeat (4) @(posedge clk_in);
      summarize();
   end
endmodule
